//--- core/swm_pkg.sv
// ****************************************************************
// Shared constants and carriers of the servo warning monitor.
// ****************************************************************
package swm_pkg;

  // ****************************************************************
  // Bus and register widths.
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 14;
  localparam int POS_W  = 32;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_ABS_AS_INC  = 14'h2005;
  localparam logic [IDX_W-1:0] IDX_OVL_RATE    = 14'h200f;
  localparam logic [IDX_W-1:0] IDX_WARN_MASK   = 14'h2014;
  localparam logic [IDX_W-1:0] IDX_DRV_CTRL1   = 14'h211f;
  localparam logic [IDX_W-1:0] IDX_IO_FIRST    = 14'h2200;
  localparam logic [IDX_W-1:0] IDX_IO_LAST     = 14'h2217;
  localparam logic [IDX_W-1:0] IDX_LOAD_RATE   = 14'h2603;
  localparam logic [IDX_W-1:0] IDX_MAIN_VOLT   = 14'h2605;
  localparam logic [IDX_W-1:0] IDX_WARN_STAT   = 14'h2700;
  localparam logic [IDX_W-1:0] IDX_SETUP_STAT  = 14'h2701;
  localparam logic [IDX_W-1:0] IDX_LMT_EN      = 14'h2710;
  localparam logic [IDX_W-1:0] IDX_LMT_POS_LO  = 14'h2711;
  localparam logic [IDX_W-1:0] IDX_LMT_POS_HI  = 14'h2712;
  localparam logic [IDX_W-1:0] IDX_LMT_NEG_LO  = 14'h2713;
  localparam logic [IDX_W-1:0] IDX_LMT_NEG_HI  = 14'h2714;
  localparam logic [IDX_W-1:0] IDX_DRV_CUR     = 14'h2720;
  localparam logic [IDX_W-1:0] IDX_MOT_CUR     = 14'h2721;

  // ****************************************************************
  // Warning bit positions in the mask and, except BIT_ZPH, in the status word.
  // ****************************************************************
  localparam int BIT_BATT     = 1;
  localparam int BIT_SWLMT    = 2;
  localparam int BIT_OVLD     = 4;
  localparam int BIT_MISMATCH = 5;
  localparam int BIT_UVOLT    = 6;
  localparam int BIT_ESTOP    = 7;
  localparam int BIT_ZPH      = 14;

  // ****************************************************************
  // Reset values and thresholds.
  // ****************************************************************
  localparam logic [REG_W-1:0] MASK_RST     = 16'h40f6;
  localparam logic [REG_W-1:0] OVL_RATE_RST = 16'h03e8;
  localparam logic [REG_W-1:0] MIN_SUPPLY_MV = 16'h5dc0;
  localparam logic [REG_W-1:0] ABS_AS_INC_ON = 16'h0001;
  localparam logic [REG_W-1:0] REG_ZERO     = 16'h0000;

  // ****************************************************************
  // Digital input and output signal assignment layout.
  // ****************************************************************
  localparam int IO_NUM      = 24;
  localparam int DI_NUM      = 16;
  localparam int IO_SEL_W    = 5;
  localparam int SIG_CODE_W  = 8;
  localparam int ASSIGN_INV  = 15;
  localparam int CTRL1_ESTOP = 0;
  localparam logic [SIG_CODE_W-1:0] SIG_NONE      = 8'h00;
  localparam logic [SIG_CODE_W-1:0] SIG_EMERGENCY = 8'h07;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } swm_bus_req_t;

  typedef struct packed {
    logic              batt_low;
    logic              zph_loss;
    logic [DI_NUM-1:0] di;
  } swm_pins_t;

endpackage

//--- core/swm_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser for a group of level inputs.
// ****************************************************************
module swm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // swm_sync

//--- core/swm_top.sv
`timescale 1ns/1ps
// Functional notes
// - Detected warnings are reported while the drive keeps running.
// - A warning drops by itself once its cause is gone.
// - A mask register holds one check bit per warning.
// - Mask bit 1 battery, bit 2 position limit, bit 4 overload.
// - Mask bit 5 mismatch, bit 6 low voltage, bit 7 emergency.
// - Mask bit 14 gates the encoder Z-phase loss alarm.
// - Overload warns when load rate exceeds the configured threshold.
// - Low voltage warns when main supply is below 24 V.
// - Assigned emergency contact input active raises emergency warning.
// - Duplicate signal in I/O assignment parameters flags setting failure.
// - Motor current above drive current raises mismatch warning.
module swm_top (
  input  wire logic                         i_clk,
  input  wire logic                         i_srst,
  input  wire swm_pkg::swm_bus_req_t        i_bus,
  input  wire swm_pkg::swm_pins_t           i_pins,
  input  wire logic [swm_pkg::POS_W-1:0]    i_pos_cmd,
  input  wire logic                         i_pos_cmd_valid,
  input  wire logic [swm_pkg::REG_W-1:0]    i_load_rate,
  input  wire logic [swm_pkg::REG_W-1:0]    i_main_mv,
  output logic      [swm_pkg::DATA_W-1:0]   o_rdata,
  output logic      [swm_pkg::REG_W-1:0]    o_warn,
  output logic                              o_warn_any,
  output logic                              o_setup_fail,
  output logic                              o_zph_alarm
);

  // ****************************************************************
  // Pin synchronisation.
  // ****************************************************************
  swm_pkg::swm_pins_t pins_s;

  // Every pin passes two flops before any detector looks at it.
  swm_sync #(
    .W ($bits(swm_pkg::swm_pins_t))
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_pins),
    .o_sync  (pins_s)
  );

  // ****************************************************************
  // Address decoding helpers.
  // ****************************************************************
  // Only aligned words decode; any other byte address is unmapped.
  function automatic logic is_idx(
    input logic [swm_pkg::ADDR_W-1:0] addr,
    input logic [swm_pkg::IDX_W-1:0]  idx
  );
    return (addr[1:0] == 2'h0) && (addr[swm_pkg::ADDR_W-1:2] == idx);
  endfunction

  function automatic logic in_io_range(
    input logic [swm_pkg::ADDR_W-1:0] addr
  );
    logic [swm_pkg::IDX_W-1:0] idx;
    idx = addr[swm_pkg::ADDR_W-1:2];
    return (addr[1:0] == 2'h0) && (idx >= swm_pkg::IDX_IO_FIRST) &&
           (idx <= swm_pkg::IDX_IO_LAST);
  endfunction

  function automatic logic [swm_pkg::IO_SEL_W-1:0] io_sel(
    input logic [swm_pkg::ADDR_W-1:0] addr
  );
    logic [swm_pkg::IDX_W-1:0] diff;
    diff = addr[swm_pkg::ADDR_W-1:2] - swm_pkg::IDX_IO_FIRST;
    return diff[swm_pkg::IO_SEL_W-1:0];
  endfunction

  function automatic logic [swm_pkg::SIG_CODE_W-1:0] sig_code(
    input logic [swm_pkg::REG_W-1:0] assign_word
  );
    return assign_word[swm_pkg::SIG_CODE_W-1:0];
  endfunction

  logic [swm_pkg::REG_W-1:0] wdat;
  logic                      wr_en;

  assign wdat  = i_bus.wdata[swm_pkg::REG_W-1:0];
  assign wr_en = i_bus.wr;

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [swm_pkg::REG_W-1:0] warn_mask_ff;
  logic [swm_pkg::REG_W-1:0] ovl_rate_ff;
  logic [swm_pkg::REG_W-1:0] abs_as_inc_ff;
  logic [swm_pkg::REG_W-1:0] drv_ctrl1_ff;
  logic [swm_pkg::REG_W-1:0] drv_cur_ff;
  logic [swm_pkg::REG_W-1:0] mot_cur_ff;
  logic                      lmt_en_ff;
  logic [swm_pkg::POS_W-1:0] lmt_pos_ff;
  logic [swm_pkg::POS_W-1:0] lmt_neg_ff;
  logic [swm_pkg::REG_W-1:0] io_assign_ff [swm_pkg::IO_NUM];

  // Warning check mask; a set bit means the warning is checked.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      warn_mask_ff <= swm_pkg::MASK_RST;
    end else if (wr_en && is_idx(i_bus.addr, swm_pkg::IDX_WARN_MASK)) begin
      warn_mask_ff <= wdat;
    end
  end

  // Overload threshold, encoder usage and drive control word.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ovl_rate_ff   <= swm_pkg::OVL_RATE_RST;
      abs_as_inc_ff <= swm_pkg::REG_ZERO;
      drv_ctrl1_ff  <= swm_pkg::REG_ZERO;
    end else if (wr_en) begin
      if (is_idx(i_bus.addr, swm_pkg::IDX_OVL_RATE)) begin
        ovl_rate_ff <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_ABS_AS_INC)) begin
        abs_as_inc_ff <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_DRV_CTRL1)) begin
        drv_ctrl1_ff <= wdat;
      end
    end
  end

  // Current capacities of the fitted drive and the configured motor.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      drv_cur_ff <= swm_pkg::REG_ZERO;
      mot_cur_ff <= swm_pkg::REG_ZERO;
    end else if (wr_en) begin
      if (is_idx(i_bus.addr, swm_pkg::IDX_DRV_CUR)) begin
        drv_cur_ff <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_MOT_CUR)) begin
        mot_cur_ff <= wdat;
      end
    end
  end

  // Software position limit; each 32-bit limit is written in halves.
  // A half takes effect on its own, so software should turn the limit
  // off while it changes both halves of one limit.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lmt_en_ff  <= 1'b0;
      lmt_pos_ff <= '0;
      lmt_neg_ff <= '0;
    end else if (wr_en) begin
      if (is_idx(i_bus.addr, swm_pkg::IDX_LMT_EN)) begin
        lmt_en_ff <= wdat[0];
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_LMT_POS_LO)) begin
        lmt_pos_ff[swm_pkg::REG_W-1:0] <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_LMT_POS_HI)) begin
        lmt_pos_ff[swm_pkg::POS_W-1:swm_pkg::REG_W] <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_LMT_NEG_LO)) begin
        lmt_neg_ff[swm_pkg::REG_W-1:0] <= wdat;
      end
      if (is_idx(i_bus.addr, swm_pkg::IDX_LMT_NEG_HI)) begin
        lmt_neg_ff[swm_pkg::POS_W-1:swm_pkg::REG_W] <= wdat;
      end
    end
  end

  // Digital input and output signal assignments; zero means unused.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int k = 0; k < swm_pkg::IO_NUM; k++) begin
        io_assign_ff[k] <= swm_pkg::REG_ZERO;
      end
    end else if (wr_en && in_io_range(i_bus.addr)) begin
      io_assign_ff[io_sel(i_bus.addr)] <= wdat;
    end
  end

  // ****************************************************************
  // Cause detectors.
  // ****************************************************************
  logic [swm_pkg::POS_W-1:0] pos_cmd_ff;
  logic                      lmt_hit;
  logic                      estop_active;
  logic                      io_dup;
  logic [swm_pkg::REG_W-1:0] cause;

  // The last accepted command stays the cause until a new one arrives.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pos_cmd_ff <= '0;
    end else if (i_pos_cmd_valid) begin
      pos_cmd_ff <= i_pos_cmd;
    end
  end

  // A command past either limit counts only while the limit is on.
  assign lmt_hit = lmt_en_ff &&
                   (($signed(pos_cmd_ff) > $signed(lmt_pos_ff)) ||
                    ($signed(pos_cmd_ff) < $signed(lmt_neg_ff)));

  // Emergency comes from any input slot assigned the emergency signal,
  // honouring that slot's inversion bit, or from the control word.
  always_comb begin
    estop_active = drv_ctrl1_ff[swm_pkg::CTRL1_ESTOP];
    for (int k = 0; k < swm_pkg::DI_NUM; k++) begin
      if ((sig_code(io_assign_ff[k]) == swm_pkg::SIG_EMERGENCY) &&
          (pins_s.di[k] ^ io_assign_ff[k][swm_pkg::ASSIGN_INV])) begin
        estop_active = 1'b1;
      end
    end
  end

  // Pairwise scan of all assignments; the array is small enough that a
  // flat comparator net is cheaper than a sequential checker.
  always_comb begin
    io_dup = 1'b0;
    for (int a = 0; a < swm_pkg::IO_NUM; a++) begin
      for (int b = a + 1; b < swm_pkg::IO_NUM; b++) begin
        if ((sig_code(io_assign_ff[a]) != swm_pkg::SIG_NONE) &&
            (sig_code(io_assign_ff[a]) == sig_code(io_assign_ff[b]))) begin
          io_dup = 1'b1;
        end
      end
    end
  end

  // Raw causes, placed at their mask bit positions.
  always_comb begin
    cause = swm_pkg::REG_ZERO;
    cause[swm_pkg::BIT_BATT] = pins_s.batt_low &&
                               (abs_as_inc_ff != swm_pkg::ABS_AS_INC_ON);
    cause[swm_pkg::BIT_SWLMT]    = lmt_hit;
    cause[swm_pkg::BIT_OVLD]     = i_load_rate > ovl_rate_ff;
    cause[swm_pkg::BIT_MISMATCH] = mot_cur_ff > drv_cur_ff;
    cause[swm_pkg::BIT_UVOLT]    = i_main_mv < swm_pkg::MIN_SUPPLY_MV;
    cause[swm_pkg::BIT_ESTOP]    = estop_active;
  end

  // ****************************************************************
  // Warning outputs.
  // ****************************************************************
  logic [swm_pkg::REG_W-1:0] nxt_warn;
  logic [swm_pkg::REG_W-1:0] warn_ff;
  logic                      warn_any_ff;
  logic                      setup_fail_ff;
  logic                      zph_alarm_ff;

  // Battery cause is already suppressed above when the encoder runs
  // incremental, so no stale warning survives that setting.
  assign nxt_warn = cause & warn_mask_ff;

  // Warnings follow their causes every cycle with no latch, so they
  // fall by themselves; nothing here stops or disables the motor.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      warn_ff     <= swm_pkg::REG_ZERO;
      warn_any_ff <= 1'b0;
    end else begin
      warn_ff     <= nxt_warn;
      warn_any_ff <= |nxt_warn;
    end
  end

  // Setting failure tracks the assignment table as it stands.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      setup_fail_ff <= 1'b0;
    end else begin
      setup_fail_ff <= io_dup;
    end
  end

  // Z-phase loss reaches the alarm path only while its bit is set.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      zph_alarm_ff <= 1'b0;
    end else begin
      zph_alarm_ff <= pins_s.zph_loss &&
                      warn_mask_ff[swm_pkg::BIT_ZPH];
    end
  end

  // ****************************************************************
  // Read port.
  // ****************************************************************
  logic [swm_pkg::REG_W-1:0]  rd_word;
  logic [swm_pkg::DATA_W-1:0] rdata_ff;

  // Unmapped or misaligned reads return zero.
  always_comb begin
    rd_word = swm_pkg::REG_ZERO;
    if (in_io_range(i_bus.addr)) begin
      rd_word = io_assign_ff[io_sel(i_bus.addr)];
    end else if (i_bus.addr[1:0] == 2'h0) begin
      unique case (i_bus.addr[swm_pkg::ADDR_W-1:2])
        swm_pkg::IDX_WARN_MASK:  rd_word = warn_mask_ff;
        swm_pkg::IDX_OVL_RATE:   rd_word = ovl_rate_ff;
        swm_pkg::IDX_ABS_AS_INC: rd_word = abs_as_inc_ff;
        swm_pkg::IDX_DRV_CTRL1:  rd_word = drv_ctrl1_ff;
        swm_pkg::IDX_LOAD_RATE:  rd_word = i_load_rate;
        swm_pkg::IDX_MAIN_VOLT:  rd_word = i_main_mv;
        swm_pkg::IDX_WARN_STAT:  rd_word = warn_ff;
        swm_pkg::IDX_SETUP_STAT: rd_word = {15'h0000, setup_fail_ff};
        swm_pkg::IDX_LMT_EN:     rd_word = {15'h0000, lmt_en_ff};
        swm_pkg::IDX_LMT_POS_LO: rd_word = lmt_pos_ff[swm_pkg::REG_W-1:0];
        swm_pkg::IDX_LMT_POS_HI:
          rd_word = lmt_pos_ff[swm_pkg::POS_W-1:swm_pkg::REG_W];
        swm_pkg::IDX_LMT_NEG_LO: rd_word = lmt_neg_ff[swm_pkg::REG_W-1:0];
        swm_pkg::IDX_LMT_NEG_HI:
          rd_word = lmt_neg_ff[swm_pkg::POS_W-1:swm_pkg::REG_W];
        swm_pkg::IDX_DRV_CUR:    rd_word = drv_cur_ff;
        swm_pkg::IDX_MOT_CUR:    rd_word = mot_cur_ff;
        default:                 rd_word = swm_pkg::REG_ZERO;
      endcase
    end
  end

  // Read data stand one cycle after the strobe and are zero otherwise.
  // Clearing them between answers keeps a stale word off the bus.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_ff <= '0;
    end else if (i_bus.rd) begin
      rdata_ff <= {16'h0000, rd_word};
    end else begin
      rdata_ff <= '0;
    end
  end

  // Every output comes straight from its flop.
  assign o_rdata      = rdata_ff;
  assign o_warn       = warn_ff;
  assign o_warn_any   = warn_any_ff;
  assign o_setup_fail = setup_fail_ff;
  assign o_zph_alarm  = zph_alarm_ff;

endmodule // swm_top

//--- bench/swm_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Port-level checker of the warning monitor.
// ****************************************************************
module swm_checker (
  input wire logic                       i_clk,
  input wire logic                       i_srst,
  input wire swm_pkg::swm_bus_req_t      i_bus,
  input wire swm_pkg::swm_pins_t         i_pins,
  input wire logic [swm_pkg::REG_W-1:0]  i_load_rate,
  input wire logic [swm_pkg::REG_W-1:0]  i_main_mv,
  input wire logic [swm_pkg::DATA_W-1:0] o_rdata,
  input wire logic [swm_pkg::REG_W-1:0]  o_warn,
  input wire logic                       o_warn_any,
  input wire logic                       o_setup_fail,
  input wire logic                       o_zph_alarm
);
  logic [15:0] mask_ff;
  logic [15:0] thr_ff;

  // Shadow copies of the mask and threshold, followed from bus writes.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask_ff <= swm_pkg::MASK_RST;
      thr_ff  <= swm_pkg::OVL_RATE_RST;
    end else if (i_bus.wr &&
                 i_bus.addr == {swm_pkg::IDX_WARN_MASK, 2'b00}) begin
      mask_ff <= i_bus.wdata[15:0];
    end else if (i_bus.wr &&
                 i_bus.addr == {swm_pkg::IDX_OVL_RATE, 2'b00}) begin
      thr_ff <= i_bus.wdata[15:0];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_rst;
    disable iff (1'b0) i_srst |=> o_warn == '0 && !o_warn_any &&
      !o_setup_fail && !o_zph_alarm;
  endproperty
  property p_any;
    o_warn_any == (|o_warn);
  endproperty
  property p_bits;
    (o_warn & ~16'h00f6) == '0;
  endproperty
  property p_idle;
    !$past(i_bus.rd) |-> o_rdata == '0;
  endproperty
  property p_mask_rd;
    !$past(i_srst) &&
      $past(i_bus.rd && i_bus.addr == {swm_pkg::IDX_WARN_MASK, 2'b00})
      |-> o_rdata == {16'h0000, $past(mask_ff)};
  endproperty
  property p_uv;
    !$past(i_srst) |-> o_warn[swm_pkg::BIT_UVOLT] ==
      $past(i_main_mv < swm_pkg::MIN_SUPPLY_MV && mask_ff[swm_pkg::BIT_UVOLT]);
  endproperty
  property p_ov;
    !$past(i_srst) |-> o_warn[swm_pkg::BIT_OVLD] ==
      $past(i_load_rate > thr_ff && mask_ff[swm_pkg::BIT_OVLD]);
  endproperty
  // The pin passes two synchroniser stages and the alarm flop, so the figure is three cycles.
  property p_zph;
    !$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3) |->
      o_zph_alarm == ($past(i_pins.zph_loss, 3) &&
      $past(mask_ff[swm_pkg::BIT_ZPH]));
  endproperty

  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  a_any: assert property (p_any)
    else $error("summary flag differs from status");
  a_bits: assert property (p_bits)
    else $error("undefined status bit set");
  a_idle: assert property (p_idle)
    else $error("read data outside the answer cycle");
  a_mask_rd: assert property (p_mask_rd)
    else $error("mask read back wrong");
  a_uv: assert property (p_uv)
    else $error("low voltage flag wrong");
  a_ov: assert property (p_ov)
    else $error("overload flag wrong");
  a_zph: assert property (p_zph)
    else $error("z phase alarm wrong");

  c_any: cover property ($rose(o_warn_any));
  c_setup: cover property ($rose(o_setup_fail));
  c_zph: cover property ($rose(o_zph_alarm));
endmodule // swm_checker

bind swm_top swm_checker u_chk (.i_clk, .i_srst, .i_bus, .i_pins,
  .i_load_rate, .i_main_mv, .o_rdata, .o_warn, .o_warn_any,
  .o_setup_fail, .o_zph_alarm);

//--- bench/swm_plant.sv
`timescale 1ns/1ps
// ****************************************************************
// Motor, encoder, supply and contact inputs seen by the monitor.
// ****************************************************************
module swm_plant (
  input  wire logic                 i_clk,
  output swm_pkg::swm_pins_t        o_pins,
  output logic [swm_pkg::POS_W-1:0] o_pos_cmd,
  output logic                      o_pos_valid,
  output logic [swm_pkg::REG_W-1:0] o_load,
  output logic [swm_pkg::REG_W-1:0] o_mv
);
  // A healthy supply at power-up, so no warning is due before stimulus.
  initial begin
    o_pins      = '0;
    o_pos_cmd   = '0;
    o_pos_valid = 1'b0;
    o_load      = '0;
    o_mv        = 16'h7530;
  end

  // New plant state lands on one edge; the command pulse lasts one cycle.
  task automatic apply(input swm_pkg::swm_pins_t p, input logic [31:0] cmd,
                       input logic [15:0] ld, input logic [15:0] mv);
    @(posedge i_clk);
    o_pins      <= p;
    o_pos_cmd   <= cmd;
    o_pos_valid <= 1'b1;
    o_load      <= ld;
    o_mv        <= mv;
    @(posedge i_clk);
    o_pos_valid <= 1'b0;
  endtask
endmodule // swm_plant

//--- bench/servo_warning_monitor_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Random self-checking bench against a behavioural model.
// ****************************************************************
module servo_warning_monitor_tb;
  logic                  i_clk  = 1'b0;
  logic                  i_srst = 1'b1;
  swm_pkg::swm_bus_req_t bus    = '0;
  swm_pkg::swm_pins_t    pins, pb;
  logic [31:0]           pos_cmd, rdata;
  logic [15:0]           load, mv, warn, ld, mvv;
  logic                  pos_valid, warn_any, setup_fail, zph_alarm;
  int                    err_count = 0;
  int                    n_compared = 0;
  int unsigned           mask, thr, absinc, ctrl1, lim_en, drv, mot;
  int unsigned           code [24];
  int unsigned           inv [24];
  int                    plim, nlim, cmd;

  always #2.5 i_clk = ~i_clk;

  swm_plant u_plant (.i_clk, .o_pins(pins), .o_pos_cmd(pos_cmd),
    .o_pos_valid(pos_valid), .o_load(load), .o_mv(mv));
  swm_top DUT (.i_clk, .i_srst, .i_bus(bus), .i_pins(pins),
    .i_pos_cmd(pos_cmd), .i_pos_cmd_valid(pos_valid), .i_load_rate(load),
    .i_main_mv(mv), .o_rdata(rdata), .o_warn(warn), .o_warn_any(warn_any),
    .o_setup_fail(setup_fail), .o_zph_alarm(zph_alarm));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] ad(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  // Each strobe is followed by an idle cycle, keeping drivers race free.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 check(rdata, exp);
    @(posedge i_clk);
  endtask

  // Expected status word from the model state, mask applied last.
  function automatic logic [15:0] exp_warn();
    logic [15:0] w;
    w = '0;
    w[swm_pkg::BIT_BATT] = pb.batt_low && absinc != 1;
    w[swm_pkg::BIT_SWLMT] = lim_en[0] && (cmd > plim || cmd < nlim);
    w[swm_pkg::BIT_OVLD] = ld > thr;
    w[swm_pkg::BIT_MISMATCH] = mot > drv;
    w[swm_pkg::BIT_UVOLT] = mvv < swm_pkg::MIN_SUPPLY_MV;
    w[swm_pkg::BIT_ESTOP] = ctrl1[0];
    for (int k = 0; k < 16; k++)
      if (code[k] == swm_pkg::SIG_EMERGENCY && (pb.di[k] ^ inv[k][0]))
        w[swm_pkg::BIT_ESTOP] = 1'b1;
    return w & mask[15:0];
  endfunction

  function automatic logic dup();
    for (int i = 0; i < 24; i++)
      for (int j = i + 1; j < 24; j++)
        if (code[i] != 0 && code[i] == code[j]) return 1'b1;
    return 1'b0;
  endfunction

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    complete_run();
  end

  // Main sequence: reset values, random sweeps, read-only and mid-run reset.
  initial begin
    void'($urandom(1442));
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(ad(swm_pkg::IDX_WARN_MASK), swm_pkg::MASK_RST);
    rd(ad(swm_pkg::IDX_OVL_RATE), swm_pkg::OVL_RATE_RST);
    rd(16'h8051, 32'h0000_0000);
    rd(16'h0000, 32'h0000_0000);
    check(warn, 16'h0000);
    for (int it = 0; it < 60; it++) begin
      mask = $urandom();
      thr = $urandom_range(0, 2000);
      absinc = $urandom_range(0, 2);
      ctrl1 = ($urandom_range(0, 7) == 0);
      lim_en = $urandom_range(0, 1);
      plim = $urandom_range(0, 1000);
      nlim = -int'($urandom_range(0, 1000));
      drv = $urandom_range(0, 20);
      mot = $urandom_range(0, 20);
      wr(ad(swm_pkg::IDX_WARN_MASK), mask[15:0]);
      wr(ad(swm_pkg::IDX_OVL_RATE), thr[15:0]);
      wr(ad(swm_pkg::IDX_ABS_AS_INC), absinc[15:0]);
      wr(ad(swm_pkg::IDX_DRV_CTRL1), ctrl1[15:0]);
      wr(ad(swm_pkg::IDX_LMT_EN), lim_en[15:0]);
      wr(ad(swm_pkg::IDX_LMT_POS_LO), plim[15:0]);
      wr(ad(swm_pkg::IDX_LMT_POS_HI), plim[31:16]);
      wr(ad(swm_pkg::IDX_LMT_NEG_LO), nlim[15:0]);
      wr(ad(swm_pkg::IDX_LMT_NEG_HI), nlim[31:16]);
      wr(ad(swm_pkg::IDX_DRV_CUR), drv[15:0]);
      wr(ad(swm_pkg::IDX_MOT_CUR), mot[15:0]);
      for (int k = 0; k < 24; k++) begin
        code[k] = ($urandom_range(0, 4) == 0) ? $urandom_range(1, 30) : 0;
        inv[k] = $urandom_range(0, 1);
        wr(ad(swm_pkg::IDX_IO_FIRST + k), {inv[k][0], 7'h00, code[k][7:0]});
      end
      pb = 18'($urandom());
      ld = $urandom_range(0, 2000);
      mvv = $urandom_range(20000, 30000);
      cmd = int'($urandom_range(0, 3000)) - 1500;
      u_plant.apply(pb, cmd, ld, mvv);
      repeat (5) @(posedge i_clk);
      #1 check(warn, exp_warn());
      check(warn_any, |exp_warn());
      check(setup_fail, dup());
      check(zph_alarm, pb.zph_loss && mask[swm_pkg::BIT_ZPH]);
      @(posedge i_clk);
      rd(ad(swm_pkg::IDX_WARN_STAT), exp_warn());
      rd(ad(swm_pkg::IDX_SETUP_STAT), dup());
      rd(ad(swm_pkg::IDX_LOAD_RATE), ld);
      rd(ad(swm_pkg::IDX_MAIN_VOLT), mvv);
      rd(ad(swm_pkg::IDX_LMT_NEG_HI), nlim[31:16]);
      rd(ad(swm_pkg::IDX_MOT_CUR), mot);
      rd(ad(swm_pkg::IDX_IO_LAST),
         {inv[23][0], 7'h00, code[23][7:0]});
    end
    wr(ad(swm_pkg::IDX_WARN_STAT), 16'hffff);
    rd(ad(swm_pkg::IDX_WARN_STAT), exp_warn());
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 check(warn, 16'h0000);
    check(setup_fail, 1'b0);
    check(warn_any, 1'b0);
    check(zph_alarm, 1'b0);
    @(posedge i_clk);
    i_srst <= 1'b0;
    rd(ad(swm_pkg::IDX_WARN_MASK), swm_pkg::MASK_RST);
    complete_run();
  end
endmodule // servo_warning_monitor_tb
